// ---- logic/idle_pattern_gen.sv ----
`timescale 1ns/1ps
module idle_pattern_gen
    import phy_tune_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [4:0] zero_count,
    output logic bit_out
);
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic bit_ff;
    logic run;
    assign run = enable && (zero_count != 5'h00);
    assign nxt_cnt = (cnt_ff >= zero_count) ? 5'h00 : cnt_ff + 5'h01;
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_ff <= 5'h00;
            bit_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            bit_ff <= (cnt_ff == 5'h00);
        end
    end
    assign bit_out = bit_ff;
endmodule : idle_pattern_gen

// ---- logic/phy_analog_tuning_regs.sv ----
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - Swing field bits 3:0 selects 10 Mb/s swing, resets to 1111.
// - Class register: 0x0020 class B, 0x0024 class A, reset 0x0020.
// - Energy threshold bits 4:0 read-write, resets to 01000.
// - Bit 14 of DC control selects fixed DC correction, reset zero.
// - Filter one cut-off from bits 12:8, resets to 01000.
// - Equalizer controls from bits 13:8, reset all zeros.
// - Bit 12 one forces core supply as 3.3 V, else detection.
// - Bits 11:10 equal 11 force IO supply 3.3 V, else detection.
// - Status: bit 2 core level, bits 1:0 IO level, read-only.
// - Pattern length: bit 5 as MSB plus four low bits elsewhere.
// - Length zero clears the pattern counter.
// - Pattern sent only while test enable bit 4 is one.
module phy_analog_tuning_regs
    import phy_tune_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [13:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [13:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CORE_SUPPLY_DETECT,
    input wire logic [1:0] IO_DETECT,
    output logic [3:0] TX10_SWING,
    output logic CLASS_A_MODE,
    output logic [4:0] ENERGY_THRESHOLD,
    output logic DC_FIXED_EN,
    output logic [4:0] FILTER1_CUTOFF,
    output logic [5:0] EQ_CONTROL,
    output logic CORE_SUPPLY_IS_33,
    output logic [1:0] IO_LEVEL,
    output logic TX100_IDLE_BIT,
    output logic IDLE_TEST_ACTIVE
);
    logic [15:0] swing_ff, class_ff, energy_ff, dc_ff, filter_ff, eq_ff, supply_ff;
    logic [15:0] dpd_ff, idle_low_ff;
    logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff, arready_ff;
    logic awready_ff, wready_ff;
    logic [13:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic core_lvl;
    logic [1:0] io_lvl;
    logic pat_bit;
    logic [3:0] swing_o_ff;
    logic class_o_ff, dc_o_ff, core_o_ff, idle_o_ff, pat_o_ff;
    logic [4:0] energy_o_ff, filter_o_ff;
    logic [5:0] eq_o_ff;
    logic [1:0] io_o_ff;

    // Write address/data capture, either order
    wire aw_take = S_AXI_AWVALID && awready_ff;
    wire w_take = S_AXI_WVALID && wready_ff;
    wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    wire [11:0] widx = awaddr_ff[13:2];
    wire [15:0] wmask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wire [15:0] wval = wdata_ff[15:0];
    wire aligned_w = (awaddr_ff[1:0] == 2'h0);
    wire hit_swing = aligned_w && (widx == IDX_SWING);
    wire hit_class = aligned_w && (widx == IDX_CLASS);
    wire hit_energy = aligned_w && (widx == IDX_ENERGY);
    wire hit_dc = aligned_w && (widx == IDX_DC);
    wire hit_filter = aligned_w && (widx == IDX_FILTER);
    wire hit_eq = aligned_w && (widx == IDX_EQ);
    wire hit_supply = aligned_w && (widx == IDX_SUPPLY);
    wire hit_dpd = aligned_w && (widx == IDX_DPD);
    wire hit_low = aligned_w && (widx == IDX_IDLE_LOW);
    wire hit_ro = aligned_w && (widx == IDX_STATUS);
    wire w_ok = hit_swing | hit_class | hit_energy | hit_dc | hit_filter | hit_eq
        | hit_supply | hit_dpd | hit_low | hit_ro;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nv & m);
    endfunction : merge

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            awaddr_ff <= 14'h0000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            awready_ff <= !aw_held_ff && !aw_take && !bvalid_ff;
            wready_ff <= !w_held_ff && !w_take && !bvalid_ff;
            if (aw_take) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_held_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= w_ok ? RESP_OKAY : RESP_SLVERR;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            swing_ff <= RST_SWING;
            class_ff <= RST_CLASS;
            energy_ff <= RST_ENERGY;
            dc_ff <= RST_DC;
            filter_ff <= RST_FILTER;
            eq_ff <= RST_EQ;
            supply_ff <= RST_SUPPLY;
            dpd_ff <= RST_DPD;
            idle_low_ff <= RST_IDLE_LOW;
        end else if (do_write) begin
            if (hit_swing) swing_ff <= merge(swing_ff, wval, wmask);
            if (hit_class) class_ff <= merge(class_ff, wval, wmask);
            if (hit_energy) energy_ff <= merge(energy_ff, wval, wmask);
            if (hit_dc) dc_ff <= merge(dc_ff, wval, wmask);
            if (hit_filter) filter_ff <= merge(filter_ff, wval, wmask);
            if (hit_eq) eq_ff <= merge(eq_ff, wval, wmask);
            if (hit_supply) supply_ff <= merge(supply_ff, wval, wmask);
            if (hit_dpd) dpd_ff <= merge(dpd_ff, wval, wmask & DPD_WMASK);
            if (hit_low) idle_low_ff <= merge(idle_low_ff, wval, wmask);
        end
    end

    supply_level_mux u_supply (
        .clk(REF_CLK),
        .rst(RST),
        .force_core(supply_ff[CORE_FORCE_BIT]),
        .force_io(supply_ff[IO_FORCE_LSB +: 2]),
        .core_det_pin(CORE_SUPPLY_DETECT),
        .io_det_pin(IO_DETECT),
        .core_lvl(core_lvl),
        .io_lvl(io_lvl)
    );

    wire [4:0] idle_len = {dpd_ff[IDLE_MSB_BIT], idle_low_ff[3:0]};
    idle_pattern_gen u_idle (
        .clk(REF_CLK),
        .rst(RST),
        .enable(dpd_ff[IDLE_EN_BIT]),
        .zero_count(idle_len),
        .bit_out(pat_bit)
    );

    // Read path
    wire ar_take = S_AXI_ARVALID && arready_ff;
    wire [11:0] ridx = S_AXI_ARADDR[13:2];
    wire r_aligned = (S_AXI_ARADDR[1:0] == 2'h0);
    wire [15:0] status_val = {13'h0000, core_lvl, io_lvl};
    logic [15:0] rmux;
    logic rhit;
    always_comb begin
        rhit = r_aligned;
        case (ridx)
            IDX_SWING: rmux = swing_ff;
            IDX_CLASS: rmux = class_ff;
            IDX_ENERGY: rmux = energy_ff;
            IDX_DC: rmux = dc_ff;
            IDX_FILTER: rmux = filter_ff;
            IDX_EQ: rmux = eq_ff;
            IDX_SUPPLY: rmux = supply_ff;
            IDX_STATUS: rmux = status_val;
            IDX_DPD: rmux = dpd_ff;
            IDX_IDLE_LOW: rmux = idle_low_ff;
            default: begin
                rmux = 16'h0000;
                rhit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else begin
            arready_ff <= !rvalid_ff && !ar_take;
            if (ar_take) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {16'h0000, rhit ? rmux : 16'h0000};
                rresp_ff <= rhit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && S_AXI_RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Registered analog controls
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            swing_o_ff <= 4'h0;
            class_o_ff <= 1'b0;
            energy_o_ff <= 5'h00;
            dc_o_ff <= 1'b0;
            filter_o_ff <= 5'h00;
            eq_o_ff <= 6'h00;
            core_o_ff <= 1'b0;
            io_o_ff <= 2'h0;
            idle_o_ff <= 1'b0;
            pat_o_ff <= 1'b0;
        end else begin
            swing_o_ff <= swing_ff[SWING_LSB +: 4];
            class_o_ff <= (class_ff == CLASS_A);
            energy_o_ff <= energy_ff[ENERGY_LSB +: 5];
            dc_o_ff <= dc_ff[DC_FIXED_BIT];
            filter_o_ff <= filter_ff[FILTER_LSB +: 5];
            eq_o_ff <= eq_ff[EQ_LSB +: 6];
            core_o_ff <= core_lvl;
            io_o_ff <= io_lvl;
            idle_o_ff <= dpd_ff[IDLE_EN_BIT];
            pat_o_ff <= pat_bit;
        end
    end

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY = wready_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign TX10_SWING = swing_o_ff;
    assign CLASS_A_MODE = class_o_ff;
    assign ENERGY_THRESHOLD = energy_o_ff;
    assign DC_FIXED_EN = dc_o_ff;
    assign FILTER1_CUTOFF = filter_o_ff;
    assign EQ_CONTROL = eq_o_ff;
    assign CORE_SUPPLY_IS_33 = core_o_ff;
    assign IO_LEVEL = io_o_ff;
    assign TX100_IDLE_BIT = pat_o_ff;
    assign IDLE_TEST_ACTIVE = idle_o_ff;

    property p_swing;
        @(posedge REF_CLK) disable iff (RST)
            !$past(RST) |-> TX10_SWING == $past(swing_ff[3:0]);
    endproperty
    a_swing: assert property (p_swing) else $error("swing output mismatch");
    property p_class;
        @(posedge REF_CLK) disable iff (RST)
            !$past(RST) |-> CLASS_A_MODE == ($past(class_ff) == CLASS_A);
    endproperty
    a_class: assert property (p_class) else $error("class decode wrong");
    property p_energy;
        @(posedge REF_CLK) disable iff (RST)
            !$past(RST) |-> ENERGY_THRESHOLD == $past(energy_ff[4:0]);
    endproperty
    a_energy: assert property (p_energy) else $error("threshold mismatch");
    property p_dc;
        @(posedge REF_CLK) disable iff (RST)
            !$past(RST) |-> DC_FIXED_EN == $past(dc_ff[14]);
    endproperty
    a_dc: assert property (p_dc) else $error("fixed dc mismatch");
    property p_filter;
        @(posedge REF_CLK) disable iff (RST)
            !$past(RST) |-> FILTER1_CUTOFF == $past(filter_ff[12:8]);
    endproperty
    a_filter: assert property (p_filter) else $error("cutoff mismatch");
    property p_eq;
        @(posedge REF_CLK) disable iff (RST)
            !$past(RST) |-> EQ_CONTROL == $past(eq_ff[13:8]);
    endproperty
    a_eq: assert property (p_eq) else $error("equalizer mismatch");
    property p_core;
        @(posedge REF_CLK) disable iff (RST) supply_ff[12] |=> CORE_SUPPLY_IS_33;
    endproperty
    a_core: assert property (p_core) else $error("core force ignored");
    property p_io;
        @(posedge REF_CLK) disable iff (RST) supply_ff[11:10] == 2'h3 |=> IO_LEVEL == 2'h3;
    endproperty
    a_io: assert property (p_io) else $error("io force ignored");
    property p_status;
        @(posedge REF_CLK) disable iff (RST)
            ar_take && r_aligned && (ridx == IDX_STATUS) |=>
                S_AXI_RDATA == {29'h0000000, $past(core_lvl), $past(io_lvl)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_idle_zero;
        @(posedge REF_CLK) disable iff (RST)
            (idle_len == 5'h00) ##1 (idle_len == 5'h00) |=> !TX100_IDLE_BIT;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("zero length sends");
    property p_idle_single;
        @(posedge REF_CLK) disable iff (RST) TX100_IDLE_BIT |=> !TX100_IDLE_BIT;
    endproperty
    a_idle_single: assert property (p_idle_single) else $error("double one");
    property p_idle_off;
        @(posedge REF_CLK) disable iff (RST) !dpd_ff[4] ##1 !dpd_ff[4] |=> !TX100_IDLE_BIT;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("pattern outside test");
    c_write: cover property (@(posedge REF_CLK) disable iff (RST) do_write && hit_class);
    c_read: cover property (@(posedge REF_CLK) disable iff (RST) ar_take);
    c_pattern: cover property (@(posedge REF_CLK) disable iff (RST) TX100_IDLE_BIT);
endmodule : phy_analog_tuning_regs

// ---- logic/phy_tune_pkg.sv ----
package phy_tune_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_SWING = 12'h403;
    localparam logic [11:0] IDX_CLASS = 12'h404;
    localparam logic [11:0] IDX_ENERGY = 12'h40D;
    localparam logic [11:0] IDX_DC = 12'h410;
    localparam logic [11:0] IDX_FILTER = 12'h416;
    localparam logic [11:0] IDX_EQ = 12'h418;
    localparam logic [11:0] IDX_SUPPLY = 12'h41F;
    localparam logic [11:0] IDX_STATUS = 12'h421;
    localparam logic [11:0] IDX_DPD = 12'h428;
    localparam logic [11:0] IDX_IDLE_LOW = 12'h027;
    // Full register reset values, class codes and the DPD write mask
    localparam logic [15:0] RST_SWING = 16'h9FCF;
    localparam logic [15:0] RST_CLASS = 16'h0020;
    localparam logic [15:0] CLASS_B = 16'h0020;
    localparam logic [15:0] CLASS_A = 16'h0024;
    localparam logic [15:0] RST_ENERGY = 16'h0008;
    localparam logic [15:0] RST_DC = 16'h2000;
    localparam logic [15:0] RST_FILTER = 16'h0870;
    localparam logic [15:0] RST_EQ = 16'h0000;
    localparam logic [15:0] RST_SUPPLY = 16'h0000;
    localparam logic [15:0] RST_DPD = 16'h0000;
    localparam logic [15:0] RST_IDLE_LOW = 16'h0000;
    localparam logic [15:0] DPD_WMASK = 16'h003F;
    // Field positions, IO force and level codes, response codes
    localparam int SWING_LSB = 0;
    localparam int ENERGY_LSB = 0;
    localparam int DC_FIXED_BIT = 14;
    localparam int FILTER_LSB = 8;
    localparam int EQ_LSB = 8;
    localparam int CORE_FORCE_BIT = 12;
    localparam int IO_FORCE_LSB = 10;
    localparam int IDLE_MSB_BIT = 5;
    localparam int IDLE_EN_BIT = 4;
    localparam logic [1:0] IO_FORCE_ON = 2'h3;
    localparam logic [1:0] IO_LVL_33 = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : phy_tune_pkg

// ---- logic/supply_level_mux.sv ----
`timescale 1ns/1ps
module supply_level_mux
    import phy_tune_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic force_core,
    input wire logic [1:0] force_io,
    input wire logic core_det_pin,
    input wire logic [1:0] io_det_pin,
    output logic core_lvl,
    output logic [1:0] io_lvl
);
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {core_det_pin, io_det_pin};
            sync2_ff <= sync1_ff;
        end
    end
    assign core_lvl = force_core ? 1'b1 : sync2_ff[2];
    assign io_lvl = (force_io == IO_FORCE_ON) ? IO_LVL_33 : sync2_ff[1:0];
endmodule : supply_level_mux

// ---- tb/phy_analog_tuning_regs_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
$display("BAD %s exp %0h got %0h", nm, ex, got); end end
module phy_analog_tuning_regs_test
    import phy_tune_pkg::*;
    ;
    logic clk = 0, rst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, avp = 0;
    logic [13:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, r, seed = 32'h63;
    logic [3:0] ws = 0, sw;
    logic [1:0] iop = 0, bresp, rresp, iol;
    logic awr, wr, bv, arr, rv, cla, dcf, avl, idb, ida;
    logic [4:0] thr, fc;
    logic [5:0] eq;
    logic [15:0] d;
    logic [11:0] idx [9];
    logic [15:0] shd [9], rv0 [9];
    int err_total = 0, tests_run = 0, k;

    always #25 clk = ~clk;

    phy_analog_tuning_regs i_dut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy),
        .CORE_SUPPLY_DETECT(avp), .IO_DETECT(iop), .TX10_SWING(sw), .CLASS_A_MODE(cla),
        .ENERGY_THRESHOLD(thr), .DC_FIXED_EN(dcf), .FILTER1_CUTOFF(fc), .EQ_CONTROL(eq),
        .CORE_SUPPLY_IS_33(avl), .IO_LEVEL(iol), .TX100_IDLE_BIT(idb),
        .IDLE_TEST_ACTIVE(ida));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [15:0] wm(input int i);
        return (i == 7) ? DPD_WMASK : (i == 8) ? 16'h000F : 16'hFFFF;
    endfunction : wm

    task give_verdict;
        $display("Checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic wr_reg(input logic [11:0] i, input logic [15:0] v, input logic [3:0] s,
            input logic [1:0] er);
        @(posedge clk);
        awa <= {i, 2'h0};
        wd <= {16'h0000, v};
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge clk);
            awv <= awv & ~awr;
            wv <= wv & ~wr;
        end while (!bv);
        brdy <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask : wr_reg

    task automatic rd_reg(input logic [11:0] i, input logic [1:0] er, output logic [15:0] v);
        @(posedge clk);
        ara <= {i, 2'h0};
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk);
            arv <= arv & ~arr;
        end while (!rv);
        rrdy <= 1'b0;
        v = rd[15:0];
        `CHK("rresp", er, rresp)
    endtask : rd_reg

    task automatic put(input int i, input logic [15:0] v, input logic [3:0] s);
        wr_reg(idx[i], v, s, RESP_OKAY);
        shd[i] = {s[1] ? v[15:8] : shd[i][15:8], s[0] ? v[7:0] : shd[i][7:0]} & wm(i);
    endtask : put

    task automatic chk_outs;
        logic [15:0] st;
        logic [1:0] io_exp;
        repeat (5) @(posedge clk);
        io_exp = (shd[6][11:10] == 2'h3) ? 2'h3 : iop;
        `CHK("swing", shd[0][3:0], sw)
        `CHK("class", shd[1] === CLASS_A, cla)
        `CHK("energy", shd[2][4:0], thr)
        `CHK("dcfix", shd[3][DC_FIXED_BIT], dcf)
        `CHK("filter", shd[4][12:8], fc)
        `CHK("eq", shd[5][13:8], eq)
        `CHK("core", shd[6][12] | avp, avl)
        `CHK("io", io_exp, iol)
        `CHK("idle_on", shd[7][IDLE_EN_BIT], ida)
        rd_reg(IDX_STATUS, RESP_OKAY, st);
        `CHK("status", {13'h0000, shd[6][12] | avp, io_exp}, st)
    endtask : chk_outs

    task automatic chk_reg(input int i);
        logic [15:0] v;
        rd_reg(idx[i], RESP_OKAY, v);
        `CHK("readback", shd[i], (i == 8) ? (v & 16'h000F) : v)
    endtask : chk_reg

    task automatic chk_all;
        for (int i = 0; i < 9; i++) begin
            chk_reg(i);
        end
        chk_outs;
    endtask : chk_all

    task automatic idle_chk(input int nz, input logic on);
        int g;
        put(8, {12'h000, nz[3:0]}, 4'hF);
        put(7, {10'h000, nz[4], on, 4'h0}, 4'hF);
        repeat (3) @(posedge clk);
        for (int p = 0; p < 3; p++) begin
            g = 0;
            do begin
                @(posedge clk);
                g++;
            end while (idb !== 1'b1 && g < 40);
            if (p > 0) `CHK("gap", (nz == 0 || !on) ? 40 : nz + 1, g)
        end
    endtask : idle_chk

    initial begin
        #(50 * 40000);
        err_total++;
        give_verdict;
    end

    initial begin
        idx = '{IDX_SWING, IDX_CLASS, IDX_ENERGY, IDX_DC, IDX_FILTER, IDX_EQ, IDX_SUPPLY,
            IDX_DPD, IDX_IDLE_LOW};
        rv0 = '{RST_SWING, RST_CLASS, RST_ENERGY, RST_DC, RST_FILTER, RST_EQ, RST_SUPPLY,
            RST_DPD, RST_IDLE_LOW};
        shd = rv0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk_all;
        foreach (rv0[i]) begin
            k = i % 3;
            put(1, (k == 0) ? CLASS_A : (k == 1) ? CLASS_B : 16'h0025, 4'hF);
            chk_outs;
        end
        put(5, 16'hFFFF, 4'h2);
        chk_all;
        wr_reg(IDX_STATUS, 16'hFFFF, 4'hF, RESP_OKAY);
        chk_outs;
        wr_reg(12'h405, 16'h1234, 4'hF, RESP_SLVERR);
        rd_reg(12'h405, RESP_SLVERR, d);
        `CHK("unmapped", 16'h0000, d)
        avp <= 1'b0;
        iop <= 2'h1;
        for (int f = 0; f < 8; f++) begin
            put(6, {3'h0, f[2:0], 10'h000}, 4'hF);
            chk_outs;
        end
        for (int t = 0; t < 40; t++) begin
            r = xs();
            k = int'(r[2:0]);
            avp <= r[3];
            iop <= r[5:4];
            put(k, r[31:16], 4'hF);
            chk_reg(k);
            chk_outs;
        end
        idle_chk(1, 1'b1);
        idle_chk(31, 1'b1);
        idle_chk(16, 1'b1);
        idle_chk(0, 1'b1);
        idle_chk(5, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        shd = rv0;
        chk_all;
        give_verdict;
    end
endmodule : phy_analog_tuning_regs_test
